//--- verilog/pdps_params.svh
// Constants of the power drawer protection sequencer
`ifndef PDPS_PARAMS_SVH
`define PDPS_PARAMS_SVH

// ****************************************
// Clock and timebase
// ****************************************
`define PDPS_CLK_HZ          10000000
`define PDPS_TICK_S          1
`define PDPS_SEC_PER_MIN     60

// ****************************************
// Shutdown timers, seconds and minutes
// ****************************************
`define PDPS_T1_S            30
`define PDPS_T2_S            60
`define PDPS_T3_S            120
`define PDPS_WATCH_MIN       10
`define PDPS_STAGE_MAX       3

// ****************************************
// Reflected power persistence
// ****************************************
`define PDPS_REFL_PERSIST    5
`define PDPS_REFL_QUIET_MIN  2

// ****************************************
// Alarm lists and channel
// ****************************************
`define PDPS_ALARM_N         32
`define PDPS_CH_NONE         12'h000

`endif

//--- verilog/pdps_pkg.sv
// Types of the power drawer protection sequencer
package pdps_pkg;

  // ****************************************
  // Supply sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_RUN,
    ST_OFF,
    ST_WATCH,
    ST_LATCHED,
    ST_MANOFF
  } pdps_state_t;

  typedef logic [9:0] pdps_sec_t;

endpackage : pdps_pkg

//--- verilog/pdps_if.sv
// Carrier between the sequencer core, its timebase and its alarm lists
`timescale 1ns/10ps
interface pdps_if #(parameter int ALARM_N = 32);
  logic               sec_tick;
  logic [ALARM_N-1:0] alarm_vec;
  logic               clr_old;
  logic [ALARM_N-1:0] cur_list;
  logic [ALARM_N-1:0] old_list;

  modport tick_src (output sec_tick);
  modport lists    (input alarm_vec, input clr_old, output cur_list, output old_list);
  modport core     (input sec_tick, input cur_list, input old_list,
                    output alarm_vec, output clr_old);
endinterface : pdps_if

//--- verilog/pdps_tick.sv
// One-second enable pulse divided from the system clock
`timescale 1ns/10ps
`include "pdps_params.svh"
module pdps_tick #(
  parameter int TICK_CYCLES = `PDPS_CLK_HZ * `PDPS_TICK_S
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Timebase out
  pdps_if.tick_src lnk
);
  logic [31:0] div_r;
  logic        tick_r;
  wire         wrap = (div_r == 32'(TICK_CYCLES - 1));

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      div_r  <= 32'h0;
      tick_r <= 1'b0;
    end else begin
      div_r  <= wrap ? 32'h0 : div_r + 32'h1;
      tick_r <= wrap;
    end
  end

  assign lnk.sec_tick = tick_r;
endmodule : pdps_tick

//--- verilog/pdps_lists.sv
// Current and old alarm lists, volatile
`timescale 1ns/10ps
`include "pdps_params.svh"
module pdps_lists #(
  parameter int ALARM_N = `PDPS_ALARM_N
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Alarm carrier
  pdps_if.lists    lnk
);
  logic [ALARM_N-1:0] cur_r;
  logic [ALARM_N-1:0] old_r;

  // ****************************************
  // Per-entry list update
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < ALARM_N; i++) begin : g_ent
      wire ended = cur_r[i] & ~lnk.alarm_vec[i];
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          cur_r[i] <= 1'b0;
          old_r[i] <= 1'b0;
        end else begin
          cur_r[i] <= lnk.alarm_vec[i];
          old_r[i] <= ended | (old_r[i] & ~lnk.clr_old);
        end
      end
    end
  endgenerate

  assign lnk.cur_list = cur_r;
  assign lnk.old_list = old_r;

  a_old_on_end: assert property (@(posedge mclk) disable iff (!arst_n)
    (cur_r[0] && !lnk.alarm_vec[0]) |=> old_r[0])
    else $error("ended alarm not moved to old list");
endmodule : pdps_lists

//--- verilog/pdps_top.sv
// Protection and supply sequencer of an RF power drawer
`timescale 1ns/10ps
`include "pdps_params.svh"
module pdps_top #(
  parameter int TICK_CYCLES = `PDPS_CLK_HZ * `PDPS_TICK_S,
  parameter int ALARM_N     = `PDPS_ALARM_N,
  parameter int CNT_W       = 16
) (
  // Clock and reset
  input  wire logic               MCLK,
  input  wire logic               ARST_N,
  // Alarm sources
  input  wire logic               LOOP_PASS,
  input  wire logic               REFL_ALARM,
  input  wire logic               TEMP_ALARM,
  input  wire logic               CURR_ALARM,
  input  wire logic [ALARM_N-1:0] ALARM_VEC,
  // Configuration
  input  wire logic               COMBINED_MODE,
  input  wire logic               SEQ_ENABLE,
  input  wire logic               CENTRAL_CTRL,
  // Channel programming
  input  wire logic               CH_WR,
  input  wire logic [11:0]        CH_IN,
  // Maintenance commands
  input  wire logic               CMD_CLR_OLD,
  input  wire logic               CMD_SHUTDOWN,
  input  wire logic               CMD_POWER_ON,
  input  wire logic               CMD_ADJUST,
  input  wire logic               CMD_ADJ_EXIT,
  input  wire logic               CMD_LOG_ERASE,
  input  wire logic               CMD_REFRESH,
  // Non-volatile counter restore
  input  wire logic [CNT_W-1:0]   NV_COUNT_INIT,
  // Supply and amplifier control
  output logic                    SUPPLY_ON,
  output logic                    AMP_ENABLE,
  output logic                    LATCHED_OFF,
  output logic [1:0]              SD_STAGE,
  output logic [9:0]              SD_REMAIN,
  // Status
  output logic [CNT_W-1:0]        SD_COUNT,
  output logic [CNT_W-1:0]        REFL_COUNT,
  output logic                    NOCH_ALARM,
  output logic [11:0]             CHANNEL,
  output logic                    ADJ_MODE,
  output logic                    TERM_TX_EN,
  output logic [ALARM_N-1:0]      CUR_ALARMS,
  output logic [ALARM_N-1:0]      OLD_ALARMS,
  // Refusal messages
  output logic                    SHUTDOWN_LOCKED_MSG,
  output logic                    PON_LOCKED_MSG,
  output logic                    ADJ_LOCKED_MSG,
  // Non-volatile log writes
  output logic                    NV_WR,
  output logic                    NV_ERASE,
  output logic [ALARM_N-1:0]      NV_CAUSE,
  output logic [1:0]              NV_STAGE,
  output logic [CNT_W-1:0]        NV_SD_COUNT
);
  localparam pdps_pkg::pdps_sec_t T1_S    = 10'(`PDPS_T1_S);
  localparam pdps_pkg::pdps_sec_t T2_S    = 10'(`PDPS_T2_S);
  localparam pdps_pkg::pdps_sec_t T3_S    = 10'(`PDPS_T3_S);
  localparam pdps_pkg::pdps_sec_t WATCH_S = 10'(`PDPS_WATCH_MIN * `PDPS_SEC_PER_MIN);
  localparam pdps_pkg::pdps_sec_t QUIET_S = 10'(`PDPS_REFL_QUIET_MIN * `PDPS_SEC_PER_MIN);
  localparam logic [2:0]          PERSIST = 3'(`PDPS_REFL_PERSIST);
  localparam logic [1:0]          STG_MAX = 2'(`PDPS_STAGE_MAX);

  // ****************************************
  // Timebase and alarm lists
  // ****************************************
  pdps_if #(.ALARM_N(ALARM_N)) link ();

  pdps_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .mclk   (MCLK),
    .arst_n (ARST_N),
    .lnk    (link)
  );

  pdps_lists #(.ALARM_N(ALARM_N)) u_lists (
    .mclk   (MCLK),
    .arst_n (ARST_N),
    .lnk    (link)
  );

  assign link.alarm_vec = ALARM_VEC;
  assign link.clr_old   = CMD_CLR_OLD;
  assign CUR_ALARMS     = link.cur_list;
  assign OLD_ALARMS     = link.old_list;

  wire tick = link.sec_tick;

  // ****************************************
  // Reflected power persistence
  // ****************************************
  logic [2:0]          consec_r;
  logic [CNT_W-1:0]    refl_cnt_r;
  pdps_pkg::pdps_sec_t quiet_r;

  wire refl_obs   = LOOP_PASS & REFL_ALARM;
  wire refl_hit   = refl_obs & (consec_r == PERSIST - 3'h1);
  wire quiet_end  = tick & ~refl_obs & (quiet_r == QUIET_S - 10'h001);
  wire [2:0] consec_nxt = !LOOP_PASS ? consec_r :
                          (!REFL_ALARM || refl_hit) ? 3'h0 : consec_r + 3'h1;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      consec_r   <= 3'h0;
      refl_cnt_r <= '0;
      quiet_r    <= 10'h000;
    end else begin
      consec_r   <= consec_nxt;
      refl_cnt_r <= refl_obs  ? refl_cnt_r + CNT_W'(1) :
                    quiet_end ? '0 : refl_cnt_r;
      quiet_r    <= (refl_obs || quiet_end) ? 10'h000 : (tick ? quiet_r + 10'h001 : quiet_r);
    end
  end

  // ****************************************
  // Shutdown causes
  // ****************************************
  wire curr_trips = CURR_ALARM & COMBINED_MODE;
  wire trip       = refl_hit | TEMP_ALARM | curr_trips;
  wire alarm_live = REFL_ALARM | TEMP_ALARM | curr_trips;
  wire seq_on     = ~COMBINED_MODE | SEQ_ENABLE;
  wire direct_off = ~seq_on & alarm_live;
  wire pon_ok     = CMD_POWER_ON & ~CENTRAL_CTRL;
  wire sd_ok      = CMD_SHUTDOWN & ~CENTRAL_CTRL;

  // ****************************************
  // Supply sequencer
  // ****************************************
  pdps_pkg::pdps_state_t st_r;
  pdps_pkg::pdps_state_t st_nxt;
  logic [1:0]            stage_r;
  logic [1:0]            stage_nxt;
  pdps_pkg::pdps_sec_t   sec_r;
  pdps_pkg::pdps_sec_t   sec_nxt;
  pdps_pkg::pdps_sec_t   dur;

  wire running  = (st_r == pdps_pkg::ST_RUN) || (st_r == pdps_pkg::ST_WATCH);
  wire tmr_done = tick & (sec_r == 10'h001);
  wire off_done = (st_r == pdps_pkg::ST_OFF) & tmr_done;
  wire sd_start = seq_on & ((running & trip) | (off_done & alarm_live));
  assign dur    = (stage_r == 2'h0) ? T1_S : (stage_r == 2'h1) ? T2_S : T3_S;

  always_comb begin
    st_nxt    = st_r;
    stage_nxt = stage_r;
    sec_nxt   = (tick && sec_r != 10'h000) ? sec_r - 10'h001 : sec_r;
    if (pon_ok) begin
      st_nxt  = pdps_pkg::ST_WATCH;
      sec_nxt = WATCH_S;
    end else if (sd_ok) begin
      st_nxt  = pdps_pkg::ST_MANOFF;
      sec_nxt = 10'h000;
    end else if (sd_start) begin
      if (stage_r == STG_MAX) begin
        st_nxt  = pdps_pkg::ST_LATCHED;
        sec_nxt = 10'h000;
      end else begin
        st_nxt    = pdps_pkg::ST_OFF;
        stage_nxt = stage_r + 2'h1;
        sec_nxt   = dur;
      end
    end else if (off_done) begin
      st_nxt  = pdps_pkg::ST_WATCH;
      sec_nxt = WATCH_S;
    end else if (st_r == pdps_pkg::ST_WATCH && tmr_done) begin
      st_nxt    = pdps_pkg::ST_RUN;
      stage_nxt = 2'h0;
    end
  end

  wire supply_nxt = ((st_nxt == pdps_pkg::ST_RUN) || (st_nxt == pdps_pkg::ST_WATCH))
                    & ~direct_off;
  wire [11:0] ch_nxt = CH_WR ? CH_IN : (supply_nxt ? CHANNEL : `PDPS_CH_NONE);
  wire [CNT_W-1:0] cnt_nxt = (CMD_LOG_ERASE ? '0 : SD_COUNT) + CNT_W'(sd_start);
  wire adj_nxt = CENTRAL_CTRL ? 1'b0 : (CMD_ADJUST ? 1'b1 : (CMD_ADJ_EXIT ? 1'b0 : ADJ_MODE));

  logic init_done_r;

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_r    <= pdps_pkg::ST_RUN;
      stage_r <= 2'h0;
      sec_r   <= 10'h000;
    end else begin
      st_r    <= st_nxt;
      stage_r <= stage_nxt;
      sec_r   <= sec_nxt;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SUPPLY_ON   <= 1'b0;
      AMP_ENABLE  <= 1'b0;
      LATCHED_OFF <= 1'b0;
      CHANNEL     <= `PDPS_CH_NONE;
      NOCH_ALARM  <= 1'b1;
      ADJ_MODE    <= 1'b0;
      TERM_TX_EN  <= 1'b0;
    end else begin
      SUPPLY_ON   <= supply_nxt;
      AMP_ENABLE  <= supply_nxt & (ch_nxt != `PDPS_CH_NONE);
      LATCHED_OFF <= (st_nxt == pdps_pkg::ST_LATCHED);
      CHANNEL     <= ch_nxt;
      NOCH_ALARM  <= (ch_nxt == `PDPS_CH_NONE);
      ADJ_MODE    <= adj_nxt;
      TERM_TX_EN  <= TERM_TX_EN | CMD_REFRESH;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SHUTDOWN_LOCKED_MSG <= 1'b0;
      PON_LOCKED_MSG      <= 1'b0;
      ADJ_LOCKED_MSG      <= 1'b0;
      REFL_COUNT          <= '0;
      SD_STAGE            <= 2'h0;
      SD_REMAIN           <= 10'h000;
    end else begin
      SHUTDOWN_LOCKED_MSG <= CMD_SHUTDOWN & CENTRAL_CTRL;
      PON_LOCKED_MSG      <= CMD_POWER_ON & CENTRAL_CTRL;
      ADJ_LOCKED_MSG      <= CMD_ADJUST & CENTRAL_CTRL;
      REFL_COUNT          <= refl_cnt_r;
      SD_STAGE            <= stage_nxt;
      SD_REMAIN           <= sec_nxt;
    end
  end

  // ****************************************
  // Shutdown counter and log writes
  // ****************************************
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      init_done_r <= 1'b0;
      SD_COUNT    <= '0;
      NV_WR       <= 1'b0;
      NV_ERASE    <= 1'b0;
      NV_CAUSE    <= '0;
      NV_STAGE    <= 2'h0;
      NV_SD_COUNT <= '0;
    end else begin
      init_done_r <= 1'b1;
      SD_COUNT    <= init_done_r ? cnt_nxt : NV_COUNT_INIT;
      NV_WR       <= sd_start & init_done_r;
      NV_ERASE    <= CMD_LOG_ERASE;
      NV_CAUSE    <= sd_start ? ALARM_VEC : NV_CAUSE;
      NV_STAGE    <= sd_start ? stage_nxt : NV_STAGE;
      NV_SD_COUNT <= sd_start ? cnt_nxt : NV_SD_COUNT;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  sequence s_first_trip;
    running && seq_on && trip && !pon_ok && !sd_ok && stage_r == 2'h0;
  endsequence

  sequence s_refl_run;
    (LOOP_PASS && REFL_ALARM) ##1 (!LOOP_PASS)[*1];
  endsequence

  a_supply_off_timing: assert property (
    (st_r == pdps_pkg::ST_OFF) |-> !SUPPLY_ON)
    else $error("supply on during shutdown count");
  a_first_timer_len: assert property (
    s_first_trip |=> (SD_REMAIN == T1_S) && (SD_STAGE == 2'h1) && !SUPPLY_ON)
    else $error("first shutdown timer not loaded");
  a_latch_third: assert property (
    (running && sd_start && !pon_ok && !sd_ok && stage_r == STG_MAX) |=> LATCHED_OFF ##1 LATCHED_OFF || $past(pon_ok))
    else $error("supply not latched off after third timer");
  a_count_step: assert property (
    (init_done_r && sd_start && !CMD_LOG_ERASE) |=> SD_COUNT == $past(SD_COUNT) + CNT_W'(1))
    else $error("shutdown counter not stepped");
  a_noch_amps_off: assert property (
    (CHANNEL == `PDPS_CH_NONE) |-> (!AMP_ENABLE && NOCH_ALARM))
    else $error("amplifiers enabled with no channel");
  a_sd_refused: assert property (
    (CMD_SHUTDOWN && CENTRAL_CTRL) |=> SHUTDOWN_LOCKED_MSG && st_r != pdps_pkg::ST_MANOFF
      || $past(st_r) == pdps_pkg::ST_MANOFF)
    else $error("shutdown not refused under central control");
  a_pon_refused: assert property (
    (CMD_POWER_ON && CENTRAL_CTRL) |=> PON_LOCKED_MSG)
    else $error("power-on not refused under central control");
  a_adj_refused: assert property (
    CENTRAL_CTRL |=> !ADJ_MODE && (ADJ_LOCKED_MSG == $past(CMD_ADJUST)))
    else $error("adjust not refused under central control");
  a_term_quiet: assert property (
    (!TERM_TX_EN && !CMD_REFRESH) |=> !TERM_TX_EN)
    else $error("terminal output started without refresh");
  a_refl_count: assert property (
    s_refl_run |-> REFL_COUNT == $past(refl_cnt_r)
      && refl_cnt_r == $past(refl_cnt_r) + CNT_W'(1))
    else $error("reflected counter not mirrored");

endmodule : pdps_top

//--- testbench/pdps_central_model.sv
// Behavioural central control drawer facing the power drawer
`timescale 1ns/10ps
module pdps_central_model (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // Bench requests
  input  wire logic        auto_en,
  input  wire logic        take_ctrl,
  input  wire logic        combined,
  input  wire logic [11:0] prog_ch,
  // Drawer status seen by the controller
  input  wire logic        supply_on,
  input  wire logic [11:0] channel,
  // Drives towards the drawer
  output logic             central_ctrl,
  output logic             combined_mode,
  output logic             ch_wr,
  output logic [11:0]      ch_in
);
  logic [1:0] wait_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      central_ctrl  <= 1'b0;
      combined_mode <= 1'b1;
      ch_wr         <= 1'b0;
      ch_in         <= 12'hfff;
      wait_r        <= 2'h0;
    end else begin
      central_ctrl  <= take_ctrl;
      combined_mode <= combined;
      ch_wr         <= 1'b0;
      ch_in         <= ~ch_in;
      if (auto_en && supply_on && channel == 12'h000 && !ch_wr) begin
        wait_r <= wait_r + 2'h1;
        if (wait_r == 2'h3) begin
          ch_wr <= 1'b1;
          ch_in <= prog_ch;
        end
      end else begin
        wait_r <= 2'h0;
      end
    end
  end
endmodule : pdps_central_model

//--- testbench/power_drawer_protection_sequencer_tb.sv
// Self-checking bench of the power drawer protection sequencer
`timescale 1ns/10ps
`include "pdps_params.svh"
module power_drawer_protection_sequencer_tb;
  localparam int TICK  = 10;
  localparam int WATCH = `PDPS_WATCH_MIN * `PDPS_SEC_PER_MIN;
  logic        mclk, arst_n, refl, auto_en, take_ctrl, combined, seq_en;
  logic [9:0]  cmd;
  logic [31:0] avec, prev_vec;
  logic [11:0] prog_ch, ch_in, channel;
  logic [15:0] nv_init, cnt, sd_count, refl_count, nv_cnt;
  logic        central, comb_mode, ch_wr, supply_on, amp_en, latched, noch, adj, term;
  logic        sd_lk, pon_lk, adj_lk, nv_wr, nv_erase;
  logic [1:0]  stage, nv_stage;
  logic [9:0]  remain;
  logic [31:0] cur, old, nv_cause;
  int          fails, comparisons, n, seed;

  pdps_central_model PARTNER (.mclk(mclk), .arst_n(arst_n), .auto_en(auto_en),
    .take_ctrl(take_ctrl), .combined(combined), .prog_ch(prog_ch), .supply_on(supply_on),
    .channel(channel), .central_ctrl(central), .combined_mode(comb_mode), .ch_wr(ch_wr),
    .ch_in(ch_in));

  pdps_top #(.TICK_CYCLES(TICK)) DUT (.MCLK(mclk), .ARST_N(arst_n), .LOOP_PASS(cmd[9]),
    .REFL_ALARM(refl), .TEMP_ALARM(cmd[7]), .CURR_ALARM(cmd[8]), .ALARM_VEC(avec),
    .COMBINED_MODE(comb_mode), .SEQ_ENABLE(seq_en), .CENTRAL_CTRL(central), .CH_WR(ch_wr),
    .CH_IN(ch_in), .CMD_CLR_OLD(cmd[0]), .CMD_SHUTDOWN(cmd[1]), .CMD_POWER_ON(cmd[2]),
    .CMD_ADJUST(cmd[3]), .CMD_ADJ_EXIT(cmd[4]), .CMD_LOG_ERASE(cmd[5]),
    .CMD_REFRESH(cmd[6]), .NV_COUNT_INIT(nv_init), .SUPPLY_ON(supply_on),
    .AMP_ENABLE(amp_en), .LATCHED_OFF(latched), .SD_STAGE(stage), .SD_REMAIN(remain),
    .SD_COUNT(sd_count), .REFL_COUNT(refl_count), .NOCH_ALARM(noch), .CHANNEL(channel),
    .ADJ_MODE(adj), .TERM_TX_EN(term), .CUR_ALARMS(cur), .OLD_ALARMS(old),
    .SHUTDOWN_LOCKED_MSG(sd_lk), .PON_LOCKED_MSG(pon_lk), .ADJ_LOCKED_MSG(adj_lk),
    .NV_WR(nv_wr), .NV_ERASE(nv_erase), .NV_CAUSE(nv_cause), .NV_STAGE(nv_stage),
    .NV_SD_COUNT(nv_cnt));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    if (fails == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  task automatic pulse(input int b);
    @(negedge mclk);
    cmd[b] = 1'b1;
    @(negedge mclk);
    cmd = '0;
  endtask : pulse

  task automatic trip_chk(input logic [1:0] st, input int secs);
    cnt = cnt + 16'h1;
    chk(supply_on, 0);
    chk(stage, st);
    chk(remain, secs);
    chk(sd_count, cnt);
    chk({nv_wr, nv_stage, nv_cnt}, {1'b1, st, cnt});
    chk(nv_cause, avec);
    n = 0;
    while (supply_on !== 1'b1 && n < secs * TICK + 20) begin
      @(negedge mclk);
      n++;
    end
    chk(n >= secs * TICK - 15 && n <= secs * TICK + 5, 1);
    chk(remain, WATCH);
  endtask : trip_chk

  // ****************************************
  // Clock and watchdog
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial begin
    #(100 * 30000);
    fails++;
    give_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = $urandom(32'h5fb4);
    arst_n = 1'b0;
    refl = 1'b0;
    cmd = '0;
    avec = '0;
    auto_en = 1'b0;
    take_ctrl = 1'b0;
    combined = 1'b1;
    seq_en = 1'b1;
    prog_ch = 12'h100 | 12'($urandom_range(1, 255));
    nv_init = 16'($urandom_range(0, 32'hff00));
    cnt = nv_init;
    repeat (2) @(negedge mclk);
    arst_n = 1'b1;
    repeat (3) @(negedge mclk);
    chk({supply_on, noch, channel, amp_en}, {2'b11, 12'h000, 1'b0});
    chk(sd_count, nv_init);
    chk({stage, latched, term}, 0);
    avec = $urandom();
    repeat (2) @(negedge mclk);
    chk(cur, avec);
    prev_vec = avec;
    avec = avec & $urandom();
    repeat (2) @(negedge mclk);
    chk(old, prev_vec & ~avec);
    pulse(0);
    chk({old, supply_on}, {32'h0, 1'b1});
    pulse(6);
    chk(term, 1);
    auto_en = 1'b1;
    repeat (10) @(negedge mclk);
    chk({channel, noch, amp_en}, {prog_ch, 2'b01});
    take_ctrl = 1'b1;
    repeat (2) @(negedge mclk);
    for (int b = 1; b <= 3; b++) begin
      pulse(b);
      chk({sd_lk, pon_lk, adj_lk}, 3'b100 >> (b - 1));
      chk({supply_on, adj}, 2'b10);
    end
    take_ctrl = 1'b0;
    repeat (2) @(negedge mclk);
    pulse(1);
    chk({supply_on, amp_en, channel}, {2'b00, 12'h000});
    pulse(2);
    chk({supply_on, remain}, {1'b1, 10'(WATCH)});
    pulse(3);
    chk(adj, 1);
    pulse(4);
    chk(adj, 0);
    repeat (10) @(negedge mclk);
    chk({channel, amp_en}, {prog_ch, 1'b1});
    pulse(7);
    trip_chk(2'd1, `PDPS_T1_S);
    pulse(7);
    trip_chk(2'd2, `PDPS_T2_S);
    pulse(7);
    trip_chk(2'd3, `PDPS_T3_S);
    pulse(7);
    chk({latched, supply_on}, 2'b10);
    repeat (50) @(negedge mclk);
    chk({latched, supply_on}, 2'b10);
    pulse(2);
    chk({latched, supply_on, remain}, {2'b01, 10'(WATCH)});
    n = 0;
    while (stage !== 2'd0 && n < WATCH * TICK + 100) begin
      @(negedge mclk);
      n++;
    end
    chk({n >= WATCH * TICK - 20, stage}, {1'b1, 2'd0});
    pulse(5);
    chk({nv_erase, sd_count}, {1'b1, 16'h0});
    cnt = 16'h0;
    for (int i = 0; i < 10; i++) begin
      refl = (i != 4);
      pulse(9);
      if (i < 9) chk(supply_on, 1);
      if (i == 8) chk(refl_count != 16'h0, 1);
    end
    refl = 1'b0;
    trip_chk(2'd1, `PDPS_T1_S);
    repeat (1000) @(negedge mclk);
    chk(refl_count, 0);
    combined = 1'b0;
    repeat (3) @(negedge mclk);
    pulse(8);
    repeat (3) @(negedge mclk);
    chk(supply_on, 1);
    combined = 1'b1;
    repeat (3) @(negedge mclk);
    seq_en = 1'b0;
    cmd[7] = 1'b1;
    repeat (2) @(negedge mclk);
    chk({supply_on, amp_en, sd_count}, {2'b00, cnt});
    cmd[7] = 1'b0;
    repeat (10) @(negedge mclk);
    chk({supply_on, amp_en, stage}, {2'b11, 2'd1});
    seq_en = 1'b1;
    pulse(8);
    trip_chk(2'd2, `PDPS_T2_S);
    pulse(8);
    cnt = cnt + 16'h1;
    chk({supply_on, stage, remain}, {1'b0, 2'd3, 10'(`PDPS_T3_S)});
    repeat (20) @(negedge mclk);
    pulse(2);
    chk({supply_on, stage, remain}, {1'b1, 2'd3, 10'(WATCH)});
    chk({sd_count, term}, {cnt, 1'b1});
    arst_n = 1'b0;
    @(negedge mclk);
    chk(cur, 0);
    chk({supply_on, latched, stage, term}, 0);
    arst_n = 1'b1;
    repeat (2) @(negedge mclk);
    chk({sd_count, supply_on, noch}, {nv_init, 2'b11});
    give_verdict();
  end
endmodule : power_drawer_protection_sequencer_tb
